// ### sas_pkg.sv
/*
  Package for the shear alarm supervisor: register offsets, reset values,
  trip cause codes, timing constants and carrier structs.
  Assumes a 125 MHz pclk and APB with 32-bit data.
*/
package sas_pkg;
  // ==========================================================
  // Timing
  localparam int CLK_MHZ = 125;
  localparam int DISP_SCAN_US = 100;
  localparam int DISP_SCAN_CYC = DISP_SCAN_US * CLK_MHZ;
  localparam int BLINK_SCANS = 2500;
  localparam int MARK_LIMIT = 10;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAUSE = 8'h08;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h0C;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h10;
  localparam logic [7:0] OFS_MIN_POS = 8'h14;
  localparam logic [7:0] OFS_ALARM_POS = 8'h18;
  localparam logic [7:0] OFS_SYNC_ERR = 8'h1C;
  localparam logic [7:0] OFS_CAR_POS = 8'h20;
  localparam logic [7:0] OFS_IDX_DIST = 8'h24;
  localparam logic [7:0] OFS_ERR_MIN = 8'h28;
  localparam logic [7:0] OFS_ERR_MAX = 8'h2C;

  // Control bits
  localparam int CTRL_AUTO = 0;
  localparam int CTRL_PMARK = 1;
  localparam int CTRL_CLEAR = 2;

  // Interrupt bits
  localparam int IRQ_TRIP = 0;
  localparam int IRQ_OVERTRAVEL = 1;
  localparam int IRQ_INDEX = 2;

  // ==========================================================
  // Trip cause codes, as read from the cause register
  localparam logic [1:0] CAUSE_NONE = 2'h0;
  localparam logic [1:0] CAUSE_NOT_HOME = 2'h1;
  localparam logic [1:0] CAUSE_MIN_POS = 2'h2;
  localparam logic [1:0] CAUSE_MARK_OVF = 2'h3;

  localparam logic [31:0] RST_MIN_POS = 32'h8000_0000;
  localparam logic [31:0] RST_ALARM_POS = 32'h7FFF_FFFF;
  localparam logic [31:0] ERR_MIN_INIT = 32'h7FFF_FFFF;
  localparam logic [31:0] ERR_MAX_INIT = 32'h8000_0000;

  typedef enum logic [1:0] {SAS_RUN, SAS_TRIP} sas_state_t;

  // Quadrature pins of one encoder, with index
  typedef struct packed {
    logic a;
    logic b;
    logic z;
  } sas_enc_t;

  // Machine signals
  typedef struct packed {
    logic reset_in;
    logic reset_button;
    logic cycle_start;
    logic at_home;
    logic mark_seen;
    logic mark_home;
    logic cut_done;
  } sas_mach_t;
endpackage

// ### sas_top.sv
/*
  Alarm and trip supervisor for a flying shear carriage controller.
  Holds the trip latch, overtravel alarm, position counters, diagnostic
  registers, deviation display and an APB register slave.
  Assumes encoder and machine pins are asynchronous to pclk, and that the
  carriage set-point count (schedule) comes from logic on pclk.
*/
// Contract
// - On trip, ready output goes low and stays low until trip clears.
// - While tripped, analogue speed output is forced to zero.
// - While tripped, closed-loop control and motion commands stop.
// - While tripped, the two centre display indicators blink.
// - While tripped, registers stay reachable and the trip cause is readable.
// - Reset input, reset button or power cycle leave the trip state.
// - Trip again at once if the cause persists after clearing.
// - In automatic production, trip when carriage reaches the minimum position.
// - Trip when a cycle is due but carriage is not home.
// - In print-mark mode, trip when more than ten marks are pending.
// - In automatic mode, raise carriage alarm when moving forward past preset.
// - Overtravel alarm only asserts its output; no stop, no trip.
// - Index distance holds line pulse count between consecutive index pulses.
// - Record min and max position error between ready-to-cut and cut done.
// - Refresh deviation display from sync error every 100 microseconds.
// - Carriage position counter counts carriage pulses and is readable.
// - Index distance uses fourfold edge counting of the line encoder.
// - Readable signed sync error is schedule minus actual carriage position.
`timescale 1ns/1ns
module sas_top #(
  parameter int DISP_SCAN = sas_pkg::DISP_SCAN_CYC,
  parameter int BLINK_LEN = sas_pkg::BLINK_SCANS,
  parameter int LED_N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire sas_pkg::sas_enc_t line_enc,
  input wire sas_pkg::sas_enc_t car_enc,
  input wire sas_pkg::sas_mach_t mach,
  input wire logic [31:0] schedule_pos,
  input wire logic [11:0] speed_cmd,
  input wire logic ctl_active,
  output logic ready,
  output logic ready_to_cut,
  output logic [11:0] speed_out,
  output logic ctl_enable,
  output logic car_alarm,
  output logic [LED_N-1:0] led,
  output logic irq
);
  // ==========================================================
  // Pin synchronisers: two flops before any logic
  localparam int NSYNC = 13;
  logic [NSYNC-1:0] sync1;
  logic [NSYNC-1:0] sync2;
  logic [NSYNC-1:0] prev;
  wire logic [NSYNC-1:0] raw_pins = {line_enc, car_enc, mach};
  // Zero after reset, so a pin already high shows one edge at release

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= '0;
      sync2 <= '0;
      prev <= '0;
    end else if (clk_en) begin
      sync1 <= raw_pins;
      sync2 <= sync1;
      prev <= sync2;
    end
  end

  sas_pkg::sas_enc_t ln;
  sas_pkg::sas_enc_t ln_q;
  sas_pkg::sas_enc_t cr;
  sas_pkg::sas_enc_t cr_q;
  sas_pkg::sas_mach_t mc;
  sas_pkg::sas_mach_t mc_q;
  assign ln = sync2[12:10];
  assign cr = sync2[9:7];
  assign mc = sync2[6:0];
  assign ln_q = prev[12:10];
  assign cr_q = prev[9:7];
  assign mc_q = prev[6:0];

  // Quadrature decode, x4: returns +1, -1 or 0 as a 2-bit code
  function automatic logic [1:0] quad(input logic a0, input logic b0,
                                      input logic a1, input logic b1);
    logic [3:0] t;
    t = {a0, b0, a1, b1};
    unique case (t)
      4'b0001, 4'b0111, 4'b1110, 4'b1000: quad = 2'b01;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: quad = 2'b11;
      default: quad = 2'b00;
    endcase
  endfunction

  function automatic logic [31:0] step(input logic [31:0] v, input logic [1:0] d);
    step = (d == 2'b01) ? v + 32'h0000_0001 :
           (d == 2'b11) ? v - 32'h0000_0001 : v;
  endfunction

  wire logic [1:0] line_dir = quad(ln_q.a, ln_q.b, ln.a, ln.b);
  wire logic [1:0] car_dir = quad(cr_q.a, cr_q.b, cr.a, cr.b);
  wire logic line_idx = ln.z & ~ln_q.z;
  wire logic clr_evt = (mc.reset_in & ~mc_q.reset_in) |
                       (mc.reset_button & ~mc_q.reset_button);
  wire logic cut_start = mc.cycle_start & ~mc_q.cycle_start;
  wire logic cut_done_rise = mc.cut_done & ~mc_q.cut_done;

  // ==========================================================
  // Software registers
  logic [2:0] ctrl;
  logic [31:0] min_pos;
  logic [31:0] alarm_pos;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic clr_sw;

  wire logic bus_wr = psel & penable & pwrite;
  wire logic auto_mode = ctrl[sas_pkg::CTRL_AUTO];
  wire logic pmark_mode = ctrl[sas_pkg::CTRL_PMARK];

  // ==========================================================
  // Counters
  logic [31:0] car_pos;
  logic [31:0] line_cnt;
  logic [31:0] idx_dist;
  logic idx_seen;
  logic [4:0] marks;
  logic [31:0] sync_err;
  logic [31:0] err_min;
  logic [31:0] err_max;
  logic window;
  logic tripped;

  wire logic [31:0] next_car_pos = step(car_pos, car_dir);
  wire logic [31:0] next_sync_err = schedule_pos - next_car_pos;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      car_pos <= '0;
      line_cnt <= '0;
      idx_dist <= '0;
      idx_seen <= 1'b0;
      sync_err <= '0;
    end else if (clk_en) begin
      car_pos <= next_car_pos;
      sync_err <= next_sync_err;
      if (line_idx) begin
        line_cnt <= '0;
        idx_seen <= 1'b1;
        // The first index only arms the measurement
        if (idx_seen) begin
          idx_dist <= step(line_cnt, line_dir);
        end
      end else begin
        line_cnt <= step(line_cnt, line_dir);
      end
    end
  end

  // Pending marks between sensor and home; saturates at 31, well past the limit
  wire logic mark_in = mc.mark_seen & ~mc_q.mark_seen;
  wire logic mark_out = mc.mark_home & ~mc_q.mark_home;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      marks <= '0;
    end else if (clk_en) begin
      if (mark_in && !mark_out && marks != 5'h1F) begin
        marks <= marks + 5'h01;
      end else if (mark_out && !mark_in && marks != 5'h00) begin
        marks <= marks - 5'h01;
      end
    end
  end

  // Error extremes over the cut window
  // A trip closes the window early; the extremes keep their values
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      window <= 1'b0;
      err_min <= sas_pkg::ERR_MIN_INIT;
      err_max <= sas_pkg::ERR_MAX_INIT;
    end else if (clk_en) begin
      if (cut_start && !tripped) begin
        window <= 1'b1;
        err_min <= next_sync_err;
        err_max <= next_sync_err;
      end else if (window) begin
        if ($signed(next_sync_err) < $signed(err_min)) err_min <= next_sync_err;
        if ($signed(next_sync_err) > $signed(err_max)) err_max <= next_sync_err;
        if (cut_done_rise || tripped) window <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Trip supervision
  sas_pkg::sas_state_t state;
  logic [1:0] cause;
  // Clearing only returns to run; a lasting cause trips again next cycle
  assign tripped = (state == sas_pkg::SAS_TRIP);

  wire logic hit_min = auto_mode && ($signed(car_pos) <= $signed(min_pos));
  wire logic not_home = cut_start && !mc.at_home;
  wire logic mark_ovf = pmark_mode && (marks > 5'(sas_pkg::MARK_LIMIT));
  wire logic [1:0] new_cause = hit_min ? sas_pkg::CAUSE_MIN_POS :
                               mark_ovf ? sas_pkg::CAUSE_MARK_OVF :
                               not_home ? sas_pkg::CAUSE_NOT_HOME : sas_pkg::CAUSE_NONE;
  wire logic clearing = clr_evt | clr_sw;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= sas_pkg::SAS_RUN;
      cause <= sas_pkg::CAUSE_NONE;
    end else if (clk_en) begin
      unique case (state)
        sas_pkg::SAS_RUN: begin
          if (new_cause != sas_pkg::CAUSE_NONE) begin
            state <= sas_pkg::SAS_TRIP;
            cause <= new_cause;
          end
        end
        sas_pkg::SAS_TRIP: begin
          if (clearing) begin
            state <= sas_pkg::SAS_RUN;
            cause <= sas_pkg::CAUSE_NONE;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Outputs
  logic [31:0] scan_cnt;
  logic [31:0] blink_cnt;
  logic blink;
  wire logic scan_tick = (scan_cnt == 32'(DISP_SCAN - 1));

  // Bar position: error clamped to the LED span around centre
  localparam int HALF = LED_N / 2;
  function automatic logic [LED_N-1:0] bar(input logic [31:0] e);
    logic [LED_N-1:0] r;
    r = '0;
    if ($signed(e) >= HALF) r[LED_N-1] = 1'b1;
    else if ($signed(e) < -HALF) r[0] = 1'b1;
    else r[HALF + int'($signed(e))] = 1'b1;
    bar = r;
  endfunction

  wire logic [LED_N-1:0] centre = {{(LED_N-HALF-1){1'b0}}, 2'b11, {(HALF-1){1'b0}}};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scan_cnt <= '0;
      blink_cnt <= '0;
      blink <= 1'b0;
      led <= '0;
    end else if (clk_en) begin
      scan_cnt <= scan_tick ? '0 : scan_cnt + 32'h0000_0001;
      if (scan_tick) begin
        if (blink_cnt == 32'(BLINK_LEN - 1)) begin
          blink_cnt <= '0;
          blink <= ~blink;
        end else begin
          blink_cnt <= blink_cnt + 32'h0000_0001;
        end
        led <= tripped ? (blink ? centre : '0) : bar(sync_err);
      end
    end
  end

  // A fresh cause drops ready and speed on the same edge that sets the latch
  wire logic moving_fwd = (car_dir == 2'b01);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ready <= 1'b0;
      speed_out <= '0;
      ctl_enable <= 1'b0;
      car_alarm <= 1'b0;
      ready_to_cut <= 1'b0;
    end else if (clk_en) begin
      ready <= !tripped && new_cause == sas_pkg::CAUSE_NONE;
      speed_out <= (tripped || new_cause != sas_pkg::CAUSE_NONE) ? '0 : speed_cmd;
      ctl_enable <= !tripped && new_cause == sas_pkg::CAUSE_NONE && ctl_active;
      ready_to_cut <= window & ~cut_done_rise;
      // Alarm only flags; it feeds no trip cause
      if (auto_mode && moving_fwd && $signed(next_car_pos) > $signed(alarm_pos)) begin
        car_alarm <= 1'b1;
      end else if (!auto_mode || $signed(next_car_pos) <= $signed(alarm_pos)) begin
        car_alarm <= 1'b0;
      end
    end
  end

  // ==========================================================
  // APB slave: zero wait states, stays live while tripped
  wire logic ovt_rise = auto_mode && moving_fwd && !car_alarm &&
                        $signed(next_car_pos) > $signed(alarm_pos);
  wire logic [2:0] irq_evt = {line_idx, ovt_rise, new_cause != sas_pkg::CAUSE_NONE && !tripped};
  wire logic hit_ctrl = paddr == sas_pkg::OFS_CTRL;
  wire logic hit_min_r = paddr == sas_pkg::OFS_MIN_POS;
  wire logic hit_alarm = paddr == sas_pkg::OFS_ALARM_POS;
  wire logic hit_istat = paddr == sas_pkg::OFS_IRQ_STAT;
  wire logic hit_imask = paddr == sas_pkg::OFS_IRQ_MASK;
  wire logic [31:0] wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};

  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    unique case (paddr)
      sas_pkg::OFS_CTRL: rd_mux = {29'h0, ctrl};
      sas_pkg::OFS_STATUS: rd_mux = {25'h0, marks, car_alarm, tripped};
      sas_pkg::OFS_CAUSE: rd_mux = {30'h0, cause};
      sas_pkg::OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat};
      sas_pkg::OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask};
      sas_pkg::OFS_MIN_POS: rd_mux = min_pos;
      sas_pkg::OFS_ALARM_POS: rd_mux = alarm_pos;
      sas_pkg::OFS_SYNC_ERR: rd_mux = sync_err;
      sas_pkg::OFS_CAR_POS: rd_mux = car_pos;
      sas_pkg::OFS_IDX_DIST: rd_mux = idx_dist;
      sas_pkg::OFS_ERR_MIN: rd_mux = err_min;
      sas_pkg::OFS_ERR_MAX: rd_mux = err_max;
      default: begin
        rd_mux = '0;
        rd_ok = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= '0;
      clr_sw <= 1'b0;
      min_pos <= sas_pkg::RST_MIN_POS;
      alarm_pos <= sas_pkg::RST_ALARM_POS;
      irq_stat <= '0;
      irq_mask <= '0;
      irq <= 1'b0;
      prdata <= '0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clk_en) begin
      pready <= psel & ~penable;
      pslverr <= psel & ~penable & ~rd_ok;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : '0;
      clr_sw <= bus_wr && pready && hit_ctrl && pstrb[0] && pwdata[sas_pkg::CTRL_CLEAR];
      if (bus_wr && pready) begin
        if (hit_ctrl && pstrb[0]) ctrl <= pwdata[2:0] & 3'b011;
        if (hit_min_r) min_pos <= (min_pos & ~wmask) | (pwdata & wmask);
        if (hit_alarm) alarm_pos <= (alarm_pos & ~wmask) | (pwdata & wmask);
        if (hit_imask && pstrb[0]) irq_mask <= pwdata[2:0];
      end
      // Set wins over a write-one clear in the same cycle
      irq_stat <= (irq_stat & ~((bus_wr && pready && hit_istat && pstrb[0]) ?
                   pwdata[2:0] : 3'b000)) | irq_evt;
      irq <= |(irq_stat & irq_mask);
    end
  end
endmodule // sas_top

// ### sas_checker.sv
/*
  Concurrent checks on the ports of the shear alarm supervisor.
  Assumes one pclk domain and the asynchronous active-low presetn.
*/
`timescale 1ns/1ns
module sas_checker #(
  parameter int DISP_SCAN = 4,
  parameter int BLINK_LEN = 2,
  parameter int LED_N = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire sas_pkg::sas_mach_t mach,
  input wire logic [11:0] speed_cmd,
  input wire logic ready,
  input wire logic [11:0] speed_out,
  input wire logic ctl_enable,
  input wire logic [LED_N-1:0] led
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // ==========================================================
  // Sequences
  sequence s_setup;
    psel && !penable && clk_en;
  endsequence
  // Trip edge with no clearing pin active
  sequence s_trip;
    $fell(ready) && !mach.reset_in && !mach.reset_button;
  endsequence

  // ==========================================================
  // Trip outputs
  chk_ready_held: assert property (s_trip |=> !ready [*3])
    else $error("ready rose straight after a trip");
  chk_speed_zero: assert property (!ready |-> speed_out == 12'h000)
    else $error("speed output not zero while tripped");
  chk_speed_pass: assert property (ready && $past(ready) |-> speed_out == $past(speed_cmd))
    else $error("speed output does not follow demand");
  chk_ctl_stop: assert property (!ready |-> !ctl_enable)
    else $error("loop enabled while tripped");
  // Display needs a scan or two to switch over
  chk_led_centre: assert property (!ready [*8] |-> (led & 8'hE7) == 8'h00)
    else $error("outer indicators lit while tripped");

  // ==========================================================
  // Register access
  chk_apb_answer: assert property (s_setup |=> pready)
    else $error("no pready one cycle after setup");
  chk_pready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  chk_unmapped_err: assert property (s_setup ##0 paddr > 8'h2C |=> pslverr && prdata == 32'h0000_0000)
    else $error("unmapped access not refused");
  chk_mapped_ok: assert property (s_setup ##0 (paddr <= 8'h2C && paddr[1:0] == 2'h0) |=> !pslverr)
    else $error("mapped access refused");
endmodule // sas_checker

bind sas_top sas_checker #(.DISP_SCAN(DISP_SCAN), .BLINK_LEN(BLINK_LEN), .LED_N(LED_N))
  sas_checker_inst (.pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel),
  .penable(penable), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .mach(mach), .speed_cmd(speed_cmd), .ready(ready), .speed_out(speed_out),
  .ctl_enable(ctl_enable), .led(led));

// ### sas_enc_model.sv
/*
  Far-side model: line and carriage quadrature encoders.
  Assumes step requests are spaced wide enough for the pin synchronisers.
*/
`timescale 1ns/1ns
module sas_enc_model #(
  parameter int Z_PERIOD = 12
) (
  input wire logic pclk,
  input wire logic car_step,
  input wire logic line_step,
  output sas_pkg::sas_enc_t car_enc,
  output sas_pkg::sas_enc_t line_enc
);
  // ==========================================================
  // Phase counters, one count per edge
  logic [1:0] car_ph = 2'h0;
  logic [1:0] line_ph = 2'h0;
  int line_cnt = 0;
  always @(posedge pclk) begin
    if (car_step) begin
      car_ph <= car_ph + 2'h1;
    end
    if (line_step) begin
      line_ph <= line_ph + 2'h1;
      line_cnt <= (line_cnt + 1) % Z_PERIOD;
    end
  end
  // B leads A going forward, as the decoder counts up; carriage index unused
  assign car_enc = '{a: car_ph[1], b: car_ph[1] ^ car_ph[0], z: 1'h0};
  assign line_enc = '{a: line_ph[1], b: line_ph[1] ^ line_ph[0], z: line_cnt == 0};
endmodule // sas_enc_model

// ### testbench.sv
/*
  Self-checking bench for the shear alarm supervisor: APB traffic,
  encoder motion and machine pin pulses, with speed, preset and schedule values from a fixed-seed source.
  Assumes the checker is bound in and the encoder model drives the pins.
*/
`timescale 1ns/1ns
module testbench;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic clk_en = 1'h1;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata, rdat, cpos;
  logic [31:0] seed = 32'h0000_001C;
  logic pready, pslverr, rerr, irq_a, ready, ready_to_cut, ctl_enable, car_alarm, irq;
  sas_pkg::sas_enc_t line_enc, car_enc;
  sas_pkg::sas_mach_t mach = 7'h08;
  logic [31:0] schedule_pos = 32'h0000_0000;
  logic [11:0] speed_cmd = 12'h000;
  logic [11:0] speed_out;
  logic ctl_active = 1'h0;
  logic car_step = 1'h0;
  logic line_step = 1'h0;
  logic [7:0] led;
  logic [1:0] blk;
  int error_cnt = 0;
  int checks = 0;
  int cyc_cnt = 0;
  int i;

  always #4 pclk = ~pclk;

  sas_top #(.DISP_SCAN(4), .BLINK_LEN(2)) sas_top_inst (
    .pclk(pclk), .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .line_enc(line_enc), .car_enc(car_enc),
    .mach(mach), .schedule_pos(schedule_pos), .speed_cmd(speed_cmd),
    .ctl_active(ctl_active), .ready(ready), .ready_to_cut(ready_to_cut),
    .speed_out(speed_out), .ctl_enable(ctl_enable), .car_alarm(car_alarm), .led(led),
    .irq(irq));
  sas_enc_model sas_enc_model_inst (.pclk(pclk), .car_step(car_step),
    .line_step(line_step), .car_enc(car_enc), .line_enc(line_enc));

  // ==========================================================
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] t;
    t = s ^ (s << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction
  function automatic logic [31:0] exp_err(input logic [31:0] sched, input logic [31:0] pos);
    return sched - pos;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    chk(pready, 1'h1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    // Idle edge, so a following call never re-drives psel in this step
    @(posedge pclk);
  endtask
  task automatic wait_ready(input logic v);
    int n;
    n = 0;
    while (ready !== v && n < 40) begin
      @(posedge pclk);
      n++;
    end
  endtask
  task automatic pulse(input int b);
    mach[b] <= 1'h1;
    tick(6);
    mach[b] <= 1'h0;
    tick(6);
  endtask
  // Pins pass two sync flops, so edges are spaced four cycles
  task automatic step(input logic car, input int n);
    repeat (n) begin
      car_step <= car;
      line_step <= !car;
      @(posedge pclk);
      car_step <= 1'h0;
      line_step <= 1'h0;
      tick(3);
    end
  endtask

  always @(posedge pclk) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 20000) begin
      error_cnt++;
      report_and_stop();
    end
  end

  // ==========================================================
  // Scenarios
  initial begin
    tick(16);
    presetn <= 1'h1;
    tick(4);
    apb(1'h0, sas_pkg::OFS_MIN_POS, 32'h0000_0000);
    chk(rdat, sas_pkg::RST_MIN_POS);
    apb(1'h0, sas_pkg::OFS_ERR_MIN, 32'h0000_0000);
    chk(rdat, sas_pkg::ERR_MIN_INIT);
    apb(1'h0, sas_pkg::OFS_ERR_MAX, 32'h0000_0000);
    chk(rdat, sas_pkg::ERR_MAX_INIT);
    apb(1'h0, 8'h40, 32'h0000_0000);
    chk(rerr, 1'h1);
    ctl_active <= 1'h1;
    for (i = 0; i < 4; i++) begin
      seed = xs(seed);
      speed_cmd <= seed[11:0];
      apb(1'h1, sas_pkg::OFS_ALARM_POS, seed);
      apb(1'h0, sas_pkg::OFS_ALARM_POS, 32'h0000_0000);
      chk(rdat, seed);
    end
    step(1'h1, 5);
    cpos = 32'h0000_0005;
    apb(1'h0, sas_pkg::OFS_CAR_POS, 32'h0000_0000);
    chk(rdat, cpos);
    schedule_pos <= seed;
    tick(2);
    apb(1'h0, sas_pkg::OFS_SYNC_ERR, 32'h0000_0000);
    chk(rdat, exp_err(seed, cpos));
    schedule_pos <= cpos;
    step(1'h0, 30);
    apb(1'h0, sas_pkg::OFS_IDX_DIST, 32'h0000_0000);
    chk(rdat, 32'h0000_000C);
    apb(1'h1, sas_pkg::OFS_IRQ_MASK, 32'h0000_0000);
    tick(2);
    irq_a = irq;
    apb(1'h1, sas_pkg::OFS_IRQ_MASK, 32'h0000_0007);
    tick(2);
    chk(irq ^ irq_a, 1'h1);
    apb(1'h1, sas_pkg::OFS_IRQ_MASK, irq_a ? 32'h0000_0000 : 32'h0000_0007);
    apb(1'h1, sas_pkg::OFS_IRQ_STAT, 32'h0000_0000);
    apb(1'h1, sas_pkg::OFS_IRQ_STAT, 32'h0000_0007);
    tick(2);
    chk(irq, 1'h0);
    // Minimum position trips only in automatic mode; overtravel only flags, never trips
    apb(1'h1, sas_pkg::OFS_MIN_POS, 32'h0000_0009);
    tick(8);
    chk(ready, 1'h1);
    apb(1'h1, sas_pkg::OFS_MIN_POS, sas_pkg::RST_MIN_POS);
    apb(1'h1, sas_pkg::OFS_CTRL, 32'h0000_0001);
    apb(1'h1, sas_pkg::OFS_ALARM_POS, 32'h0000_0007);
    step(1'h1, 4);
    cpos = 32'h0000_0009;
    schedule_pos <= cpos;
    chk(car_alarm, 1'h1);
    chk(ready, 1'h1);
    apb(1'h1, sas_pkg::OFS_ALARM_POS, sas_pkg::RST_ALARM_POS);
    apb(1'h1, sas_pkg::OFS_MIN_POS, cpos);
    wait_ready(1'h0);
    chk(ready, 1'h0);
    apb(1'h0, sas_pkg::OFS_CAUSE, 32'h0000_0000);
    chk(rdat, sas_pkg::CAUSE_MIN_POS);
    chk(speed_out, 12'h000);
    chk(ctl_enable, 1'h0);
    blk = led[4:3];
    i = 0;
    while (led[4:3] === blk && i < 60) begin
      @(posedge pclk);
      i++;
    end
    chk(i < 60, 1'h1);
    pulse(6);
    tick(4);
    chk(ready, 1'h0);
    apb(1'h1, sas_pkg::OFS_MIN_POS, sas_pkg::RST_MIN_POS);
    tick(4);
    chk(ready, 1'h0);
    pulse(5);
    wait_ready(1'h1);
    chk(ready, 1'h1);
    mach.at_home <= 1'h0;
    pulse(4);
    wait_ready(1'h0);
    apb(1'h0, sas_pkg::OFS_CAUSE, 32'h0000_0000);
    chk(rdat, sas_pkg::CAUSE_NOT_HOME);
    chk(irq, 1'h1);
    mach.at_home <= 1'h1;
    apb(1'h1, sas_pkg::OFS_CTRL, 32'h0000_0005);
    apb(1'h1, sas_pkg::OFS_IRQ_STAT, 32'h0000_0007);
    wait_ready(1'h1);
    chk(ready, 1'h1);
    tick(2);
    chk(irq, 1'h0);
    pulse(4);
    chk(ready_to_cut, 1'h1);
    schedule_pos <= cpos + 32'h0000_0003;
    tick(4);
    schedule_pos <= cpos - 32'h0000_0002;
    tick(4);
    schedule_pos <= cpos;
    pulse(0);
    apb(1'h0, sas_pkg::OFS_ERR_MIN, 32'h0000_0000);
    chk(rdat, exp_err(cpos - 32'h0000_0002, cpos));
    apb(1'h0, sas_pkg::OFS_ERR_MAX, 32'h0000_0000);
    chk(rdat, exp_err(cpos + 32'h0000_0003, cpos));
    apb(1'h1, sas_pkg::OFS_CTRL, 32'h0000_0003);
    repeat (10) pulse(2);
    chk(ready, 1'h1);
    pulse(2);
    wait_ready(1'h0);
    apb(1'h0, sas_pkg::OFS_CAUSE, 32'h0000_0000);
    chk(rdat, sas_pkg::CAUSE_MARK_OVF);
    report_and_stop();
  end
endmodule // testbench
